// ===== design/dss_sequencer.sv
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
// Overview of operation
// - Starts on command at power-up, power-cut restart, fault reset.
// - Start mode: 0 direct, 1 after DC brake, 2 after speed tracking.
// - Direct start outputs the start frequency (to 50.00Hz, default 0.50Hz).
// - Start frequency is held for the hold time, up to 50.0 s.
// - DC-brake start injects set current for set time before ramping.
// - Ramp profile: 0 straight line, 1 S-curve with section timing on deceleration only.
// - Deceleration S-curve starting section up to 50.0 s, default 0.1 s.
// - Stop decelerates (0, default) or removes output to coast (1).
// - At brake start frequency, wait the delay, then apply stop brake.
// - Reversal switches at zero, start frequency or stop speed; deadzone.
// - Stop speed threshold compared to set or detected speed.
// - Lockout 0 ignores terminal run held at power-up; 1 acts on it.
// - Below lower limit: run at limit, stop, or sleep; coast or decel.
// - Wake delay applies only when low-limit action is sleep.
// - Automatic power-cut restart only when enabled; disabled by default.
// - Power-cut restart waits the programmed time, default 1.0 s.
// - At zero frequency: no voltage, voltage, or stop brake current.
// - Emergency stop decelerates with its own time, default 2.0 s.
// - Run commands come only from the selected keypad/terminal/comm source.
// - Deceleration S-curve ending section up to 50.0 s, default 0.1 s.
module dss_sequencer #(
  parameter int TICK_CYCLES = dss_pkg::TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic keypad_run_i,
  input wire logic keypad_rev_i,
  input wire logic term_fwd_i,
  input wire logic term_rev_i,
  input wire logic estop_i,
  input wire logic power_ok_i,
  input wire logic fault_i,
  input wire logic fault_reset_i,
  input wire logic [15:0] target_freq_i,
  input wire logic [15:0] speed_i,
  output logic out_enable_o,
  output logic out_dir_o,
  output logic [15:0] out_freq_o,
  output logic dc_brake_o,
  output logic [15:0] dc_current_o,
  output logic running_o
);

  if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_chk
    $error("TICK_CYCLES must lie in 1..65535");
  end

  function automatic logic [31:0] scale(input logic [15:0] v,
                                        input logic [15:0] k);
    logic [31:0] p;
    p = {16'h0000, v} * {16'h0000, k};
    return p;
  endfunction : scale

  logic [31:0] regs_reg [0:dss_pkg::REG_CNT-1];
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic [1:0] init_cnt_reg;
  logic block_reg;
  logic [15:0] tick_cnt_reg;
  logic tick_reg;
  logic [31:0] timer_reg;
  logic [31:0] ramp_cnt_reg;
  logic [31:0] hold_cnt_reg;
  logic [15:0] freq_reg;
  logic dir_reg;
  logic estop_lat_reg;
  logic rev_lat_reg;
  logic sleep_lat_reg;
  logic was_run_reg;
  dss_pkg::dss_state_t st_reg;
  dss_pkg::dss_state_t st_next;
  localparam int LO = dss_pkg::LO;
  localparam int HI = dss_pkg::HI;

  logic [31:0] cfg;
  logic kp_run, kp_rev, t_fwd, t_rev, estop_pin, power_ok;
  logic init, run_req, dir_req, estop, below_lim, low_stop, coast;
  logic stop_req, rev_req, at_stop_spd, switch_ok, tm_done, ramp_step;
  logic curve_on, go_sleep, zero_hz;
  logic [15:0] spd, run_tgt, ramp_time;
  logic [31:0] tm_lim, interval;
  dss_pkg::dss_state_t start_st, rest_st;

  assign cfg = regs_reg[dss_pkg::IDX_CFG];
  assign {power_ok, estop_pin, t_rev, t_fwd, kp_rev, kp_run} = sync2_reg;
  assign init = init_cnt_reg != dss_pkg::INIT_CYCLES;

  // Pin synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
    end else begin
      sync1_reg <= {power_ok_i, estop_i, term_rev_i, term_fwd_i,
                    keypad_rev_i, keypad_run_i};
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      init_cnt_reg <= 2'h0;
    end else if (init) begin
      init_cnt_reg <= init_cnt_reg + 2'h1;
    end
  end

  // Run command source selection
  always_comb begin
    run_req = 1'b0;
    dir_req = 1'b0;
    case (cfg[dss_pkg::CFG_SRC +: 2])
      dss_pkg::SRC_KEYPAD: begin
        run_req = kp_run;
        dir_req = kp_rev;
      end
      dss_pkg::SRC_TERM: begin
        run_req = t_fwd | t_rev;
        dir_req = t_rev & ~t_fwd;
      end
      dss_pkg::SRC_COMM: begin
        run_req = regs_reg[dss_pkg::IDX_COMM][dss_pkg::COMM_RUN];
        dir_req = regs_reg[dss_pkg::IDX_COMM][dss_pkg::COMM_REV];
      end
      default: begin
        run_req = 1'b0;
        dir_req = 1'b0;
      end
    endcase
  end

  // Blocks a terminal run command held over power-up (lockout 0), or any run command held over an unrestarted power cut
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      block_reg <= 1'b1;
    end else if (init) begin
      block_reg <= run_req && !cfg[dss_pkg::CFG_LOCK] &&
                   cfg[dss_pkg::CFG_SRC +: 2] == dss_pkg::SRC_TERM;
    end else if (!run_req) begin
      block_reg <= 1'b0;
    end else if (st_reg == dss_pkg::ST_PWROFF && power_ok &&
                 st_next == dss_pkg::ST_IDLE) begin
      block_reg <= 1'b1;
    end
  end

  // Fixed timebase tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else if (tick_cnt_reg == 16'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= 16'h0000;
      tick_reg <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      tick_reg <= 1'b0;
    end
  end

  assign estop = estop_pin |
                 regs_reg[dss_pkg::IDX_COMM][dss_pkg::COMM_ESTOP];
  assign below_lim = target_freq_i < regs_reg[dss_pkg::IDX_LIMIT][15:0];
  assign low_stop = below_lim &&
                    cfg[dss_pkg::CFG_LLA +: 2] != dss_pkg::LLA_RUN;
  assign run_tgt = below_lim ? regs_reg[dss_pkg::IDX_LIMIT][15:0] :
                   target_freq_i;
  assign stop_req = !run_req || block_reg || estop || low_stop;
  assign coast = !estop && (low_stop && run_req && !block_reg ?
                 !cfg[dss_pkg::CFG_LLA_DEC] : cfg[dss_pkg::CFG_STOP]);
  assign go_sleep = low_stop && run_req && !block_reg && !estop &&
                    cfg[dss_pkg::CFG_LLA +: 2] == dss_pkg::LLA_SLEEP;
  assign rev_req = run_req && !block_reg && dir_req != dir_reg;
  assign spd = cfg[dss_pkg::CFG_SPDSRC] ? speed_i : freq_reg;
  assign at_stop_spd = spd <= regs_reg[dss_pkg::IDX_REVERSE][HI +: 16];
  assign zero_hz = freq_reg == 16'h0000;

  always_comb begin
    case (cfg[dss_pkg::CFG_START +: 2])
      dss_pkg::START_BRAKE: start_st = dss_pkg::ST_PREBRAKE;
      dss_pkg::START_TRACK: start_st = dss_pkg::ST_TRACK;
      default: start_st = dss_pkg::ST_HOLD;
    endcase
    rest_st = sleep_lat_reg ? dss_pkg::ST_SLEEP : dss_pkg::ST_IDLE;
    case (cfg[dss_pkg::CFG_REV +: 2])
      dss_pkg::REV_AT_ZERO: switch_ok = zero_hz;
      dss_pkg::REV_AT_START:
        switch_ok = freq_reg <= regs_reg[dss_pkg::IDX_START][LO +: 16];
      dss_pkg::REV_AT_STOPSPD: switch_ok = at_stop_spd && hold_cnt_reg >=
        scale(regs_reg[dss_pkg::IDX_DELAY][LO +: 16], dss_pkg::TICKS_PER_DS);
      default: switch_ok = zero_hz;
    endcase
  end

  // Time limit of the current state
  always_comb begin
    case (st_reg)
      dss_pkg::ST_PWRWAIT: tm_lim = scale(regs_reg[dss_pkg::IDX_WAKE]
        [HI +: 16], dss_pkg::TICKS_PER_DS);
      dss_pkg::ST_PREBRAKE: tm_lim = scale(regs_reg[dss_pkg::IDX_BRK_START]
        [LO +: 16], dss_pkg::TICKS_PER_CS);
      dss_pkg::ST_HOLD: tm_lim = scale(regs_reg[dss_pkg::IDX_START]
        [HI +: 16], dss_pkg::TICKS_PER_DS);
      dss_pkg::ST_BRKWAIT: tm_lim = scale(regs_reg[dss_pkg::IDX_STOP_BRK]
        [LO +: 16], dss_pkg::TICKS_PER_CS);
      dss_pkg::ST_BRAKE: tm_lim = scale(regs_reg[dss_pkg::IDX_STOP_BRK]
        [HI +: 16], dss_pkg::TICKS_PER_CS);
      dss_pkg::ST_DEADZONE: tm_lim = scale(regs_reg[dss_pkg::IDX_REVERSE]
        [LO +: 16], dss_pkg::TICKS_PER_DS);
      dss_pkg::ST_SLEEP: tm_lim = scale(regs_reg[dss_pkg::IDX_WAKE]
        [LO +: 16], dss_pkg::TICKS_PER_DS);
      default: tm_lim = 32'h0000_0000;
    endcase
  end
  assign tm_done = timer_reg >= tm_lim;

  // Ramp rate, halved inside the S-curve sections
  always_comb begin
    if (st_reg == dss_pkg::ST_DECEL && estop_lat_reg) begin
      ramp_time = regs_reg[dss_pkg::IDX_DELAY][HI +: 16];
    end else if (st_reg == dss_pkg::ST_DECEL || freq_reg > run_tgt) begin
      ramp_time = regs_reg[dss_pkg::IDX_RAMP][HI +: 16];
    end else begin
      ramp_time = regs_reg[dss_pkg::IDX_RAMP][LO +: 16];
    end
    curve_on = cfg[dss_pkg::CFG_RAMP] && st_reg == dss_pkg::ST_DECEL &&
      (timer_reg < scale(regs_reg[dss_pkg::IDX_CURVE][LO +: 16],
                         dss_pkg::TICKS_PER_DS) ||
       32'(freq_reg) <= scale(regs_reg[dss_pkg::IDX_CURVE][HI +: 16],
                              dss_pkg::CURVE_BAND_PER_DS));
    interval = scale(ramp_time, dss_pkg::RAMP_TICKS_PER_DS);
    if (curve_on) begin
      interval = {interval[30:0], 1'b0};
    end
  end
  assign ramp_step = tick_reg && ramp_cnt_reg >= interval;

  // Sequencer
  always_comb begin
    st_next = st_reg;
    if (init) begin
      st_next = dss_pkg::ST_IDLE;
    end else if (!power_ok) begin
      st_next = dss_pkg::ST_PWROFF;
    end else if (fault_i && st_reg != dss_pkg::ST_PWROFF) begin
      st_next = dss_pkg::ST_FAULT;
    end else begin
      case (st_reg)
        dss_pkg::ST_IDLE:
          if (!stop_req) st_next = start_st;
        dss_pkg::ST_PWROFF:
          if (cfg[dss_pkg::CFG_RESTART] && was_run_reg) begin
            st_next = dss_pkg::ST_PWRWAIT;
          end else begin
            st_next = dss_pkg::ST_IDLE;
          end
        dss_pkg::ST_PWRWAIT:
          if (tm_done) st_next = start_st;
        dss_pkg::ST_FAULT:
          if (fault_reset_i) begin
            st_next = stop_req ? dss_pkg::ST_IDLE : start_st;
          end
        dss_pkg::ST_PREBRAKE:
          if (stop_req) begin
            st_next = dss_pkg::ST_IDLE;
          end else if (tm_done) begin
            st_next = dss_pkg::ST_HOLD;
          end
        dss_pkg::ST_TRACK: st_next = dss_pkg::ST_RUN;
        dss_pkg::ST_HOLD, dss_pkg::ST_RUN:
          if (stop_req && coast) begin
            st_next = go_sleep ? dss_pkg::ST_SLEEP : dss_pkg::ST_IDLE;
          end else if (stop_req || rev_req) begin
            st_next = dss_pkg::ST_DECEL;
          end else if (st_reg == dss_pkg::ST_HOLD && tm_done) begin
            st_next = dss_pkg::ST_RUN;
          end
        dss_pkg::ST_DECEL:
          if (rev_lat_reg) begin
            if (switch_ok) st_next = dss_pkg::ST_DEADZONE;
          end else if (!stop_req && !estop_lat_reg) begin
            st_next = dss_pkg::ST_RUN;
          end else if (freq_reg <=
                       regs_reg[dss_pkg::IDX_BRK_START][HI +: 16]) begin
            st_next = dss_pkg::ST_BRKWAIT;
          end
        dss_pkg::ST_BRKWAIT:
          if (tm_done) st_next = dss_pkg::ST_BRAKE;
        dss_pkg::ST_BRAKE:
          if (tm_done) st_next = rest_st;
        dss_pkg::ST_DEADZONE:
          if (tm_done) st_next = dss_pkg::ST_HOLD;
        dss_pkg::ST_SLEEP:
          if (!run_req || block_reg || estop) begin
            st_next = dss_pkg::ST_IDLE;
          end else if (!below_lim && tm_done) begin
            st_next = start_st;
          end
        default: st_next = dss_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= dss_pkg::ST_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // State timers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_reg <= 32'h0000_0000;
      ramp_cnt_reg <= 32'h0000_0000;
      hold_cnt_reg <= 32'h0000_0000;
    end else begin
      if (st_next != st_reg ||
          (st_reg == dss_pkg::ST_SLEEP && below_lim)) begin
        timer_reg <= 32'h0000_0000;
      end else if (tick_reg && timer_reg != 32'hFFFF_FFFF) begin
        timer_reg <= timer_reg + 32'h0000_0001;
      end
      if (st_next != st_reg || ramp_step) begin
        ramp_cnt_reg <= 32'h0000_0000;
      end else if (tick_reg) begin
        ramp_cnt_reg <= ramp_cnt_reg + 32'h0000_0001;
      end
      if (st_reg != dss_pkg::ST_DECEL || !at_stop_spd) begin
        hold_cnt_reg <= 32'h0000_0000;
      end else if (tick_reg && hold_cnt_reg != 32'hFFFF_FFFF) begin
        hold_cnt_reg <= hold_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // Stop context and direction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      estop_lat_reg <= 1'b0;
      rev_lat_reg <= 1'b0;
      sleep_lat_reg <= 1'b0;
      was_run_reg <= 1'b0;
      dir_reg <= 1'b0;
    end else begin
      if (st_next == dss_pkg::ST_DECEL && st_reg != dss_pkg::ST_DECEL) begin
        estop_lat_reg <= estop;
        rev_lat_reg <= !stop_req && rev_req;
        sleep_lat_reg <= go_sleep;
      end else if (st_next != dss_pkg::ST_DECEL) begin
        estop_lat_reg <= 1'b0;
        rev_lat_reg <= 1'b0;
      end
      if (st_next == dss_pkg::ST_IDLE) begin
        sleep_lat_reg <= 1'b0;
      end
      if (st_next == dss_pkg::ST_PWROFF && st_reg != dss_pkg::ST_PWROFF) begin
        was_run_reg <= running_o;
      end
      if (st_next == start_st && st_reg != start_st &&
          st_reg != dss_pkg::ST_PWRWAIT) begin
        dir_reg <= dir_req;
      end else if (st_reg == dss_pkg::ST_DEADZONE &&
                   st_next == dss_pkg::ST_HOLD) begin
        dir_reg <= dir_req;
      end
    end
  end

  // Output frequency
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      freq_reg <= 16'h0000;
    end else begin
      case (st_next)
        dss_pkg::ST_HOLD:
          freq_reg <= regs_reg[dss_pkg::IDX_START][LO +: 16];
        dss_pkg::ST_RUN:
          if (st_reg == dss_pkg::ST_TRACK) begin
            freq_reg <= speed_i;
          end else if (ramp_step && freq_reg < run_tgt) begin
            freq_reg <= freq_reg + 16'h0001;
          end else if (ramp_step && freq_reg > run_tgt) begin
            freq_reg <= freq_reg - 16'h0001;
          end
        dss_pkg::ST_DECEL:
          if (ramp_step && !zero_hz) freq_reg <= freq_reg - 16'h0001;
        default: freq_reg <= 16'h0000;
      endcase
    end
  end

  // Power stage drive
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_enable_o <= 1'b0;
      out_dir_o <= 1'b0;
      out_freq_o <= 16'h0000;
      dc_brake_o <= 1'b0;
      dc_current_o <= 16'h0000;
      running_o <= 1'b0;
    end else begin
      out_dir_o <= dir_reg;
      out_freq_o <= freq_reg;
      running_o <= (st_reg & (dss_pkg::ST_PREBRAKE | dss_pkg::ST_TRACK |
        dss_pkg::ST_HOLD | dss_pkg::ST_RUN | dss_pkg::ST_DECEL |
        dss_pkg::ST_BRKWAIT | dss_pkg::ST_BRAKE |
        dss_pkg::ST_DEADZONE)) != 13'h0000;
      out_enable_o <= 1'b0;
      dc_brake_o <= 1'b0;
      dc_current_o <= 16'h0000;
      case (st_reg)
        dss_pkg::ST_PREBRAKE: begin
          out_enable_o <= 1'b1;
          dc_brake_o <= 1'b1;
          dc_current_o <= regs_reg[dss_pkg::IDX_CURRENT][LO +: 16];
        end
        dss_pkg::ST_BRAKE: begin
          out_enable_o <= 1'b1;
          dc_brake_o <= 1'b1;
          dc_current_o <= regs_reg[dss_pkg::IDX_CURRENT][HI +: 16];
        end
        dss_pkg::ST_HOLD, dss_pkg::ST_RUN:
          if (!zero_hz) begin
            out_enable_o <= 1'b1;
          end else if (cfg[dss_pkg::CFG_ZERO +: 2] == dss_pkg::ZERO_VOLT) begin
            out_enable_o <= 1'b1;
          end else if (cfg[dss_pkg::CFG_ZERO +: 2] ==
                       dss_pkg::ZERO_BRAKE) begin
            out_enable_o <= 1'b1;
            dc_brake_o <= 1'b1;
            dc_current_o <= regs_reg[dss_pkg::IDX_CURRENT][HI +: 16];
          end
        dss_pkg::ST_TRACK, dss_pkg::ST_DECEL: out_enable_o <= 1'b1;
        default: out_enable_o <= 1'b0;
      endcase
    end
  end

  // APB slave: one wait-free access phase, answer registered in setup
  logic [3:0] idx;
  logic mapped;
  assign idx = paddr_i[5:2];
  assign mapped = paddr_i[1:0] == 2'h0 && paddr_i[7:6] == 2'h0 &&
                  int'(idx) <= dss_pkg::IDX_LAST;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !mapped;
      if (psel_i && !penable_i) begin
        if (!mapped || pwrite_i) begin
          prdata_o <= 32'h0000_0000;
        end else if (int'(idx) == dss_pkg::IDX_STATUS) begin
          prdata_o <= {16'h0000, block_reg, dc_brake_o, out_enable_o,
                       st_reg};
        end else if (int'(idx) == dss_pkg::IDX_FREQ) begin
          prdata_o <= {dir_reg, 15'h0000, freq_reg};
        end else begin
          prdata_o <= regs_reg[idx];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      regs_reg <= dss_pkg::RST_VAL;
    end else if (psel_i && penable_i && pready_o && pwrite_i && mapped &&
                 int'(idx) < dss_pkg::REG_CNT) begin
      regs_reg[idx] <= pwdata_i;
    end
  end

endmodule : dss_sequencer

// ===== design/dss_pkg.sv
package dss_pkg;

  // Timebase: 50 MHz clock, 10 us tick
  localparam int CLK_NS = 20;
  localparam int TICK_NS = 10_000;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  localparam int CS_NS = 10_000_000;
  localparam int DS_NS = 100_000_000;
  localparam logic [15:0] TICKS_PER_CS = 16'(CS_NS / TICK_NS);
  localparam logic [15:0] TICKS_PER_DS = 16'(DS_NS / TICK_NS);
  // Ramp times are quoted from zero to 50.00 Hz in 0.01 Hz units
  localparam int RAMP_BASE_UNITS = 5000;
  localparam logic [15:0] RAMP_TICKS_PER_DS =
    16'(DS_NS / TICK_NS / RAMP_BASE_UNITS);
  // S-curve end band: frequency units per 0.1 s of end section
  localparam logic [15:0] CURVE_BAND_PER_DS = 16'h0019;
  localparam logic [1:0] INIT_CYCLES = 2'h3;

  // Register indices (byte address = 4 * index)
  localparam int REG_CNT = 12;
  localparam int IDX_CFG = 0;
  localparam int IDX_START = 1;
  localparam int IDX_BRK_START = 2;
  localparam int IDX_CURRENT = 3;
  localparam int IDX_STOP_BRK = 4;
  localparam int IDX_REVERSE = 5;
  localparam int IDX_WAKE = 6;
  localparam int IDX_DELAY = 7;
  localparam int IDX_CURVE = 8;
  localparam int IDX_RAMP = 9;
  localparam int IDX_LIMIT = 10;
  localparam int IDX_COMM = 11;
  localparam int IDX_STATUS = 12;
  localparam int IDX_FREQ = 13;
  localparam int IDX_LAST = 13;

  // Halves of a paired register
  localparam int LO = 0;
  localparam int HI = 16;

  // Configuration word fields
  localparam int CFG_SRC = 0;
  localparam int CFG_START = 2;
  localparam int CFG_RAMP = 4;
  localparam int CFG_STOP = 5;
  localparam int CFG_REV = 6;
  localparam int CFG_SPDSRC = 8;
  localparam int CFG_LOCK = 9;
  localparam int CFG_LLA = 10;
  localparam int CFG_LLA_DEC = 12;
  localparam int CFG_RESTART = 13;
  localparam int CFG_ZERO = 14;
  // Software command word fields
  localparam int COMM_RUN = 0;
  localparam int COMM_REV = 1;
  localparam int COMM_ESTOP = 2;

  localparam logic [1:0] SRC_KEYPAD = 2'h0;
  localparam logic [1:0] SRC_TERM = 2'h1;
  localparam logic [1:0] SRC_COMM = 2'h2;
  localparam logic [1:0] START_DIRECT = 2'h0;
  localparam logic [1:0] START_BRAKE = 2'h1;
  localparam logic [1:0] START_TRACK = 2'h2;
  localparam logic [1:0] REV_AT_ZERO = 2'h0;
  localparam logic [1:0] REV_AT_START = 2'h1;
  localparam logic [1:0] REV_AT_STOPSPD = 2'h2;
  localparam logic [1:0] LLA_RUN = 2'h0;
  localparam logic [1:0] LLA_SLEEP = 2'h2;
  localparam logic [1:0] ZERO_VOLT = 2'h1;
  localparam logic [1:0] ZERO_BRAKE = 2'h2;

  localparam logic [31:0] RST_VAL [0:REG_CNT-1] = '{
    32'h0000_0140, 32'h0000_0032, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0032_0000, 32'h000A_0000, 32'h0014_0000,
    32'h0001_0001, 32'h0064_0064, 32'h0000_0000, 32'h0000_0000};

  typedef enum logic [12:0] {
    ST_IDLE = 13'h0001, ST_PWROFF = 13'h0002, ST_PWRWAIT = 13'h0004,
    ST_FAULT = 13'h0008, ST_PREBRAKE = 13'h0010, ST_TRACK = 13'h0020,
    ST_HOLD = 13'h0040, ST_RUN = 13'h0080, ST_DECEL = 13'h0100,
    ST_BRKWAIT = 13'h0200, ST_BRAKE = 13'h0400, ST_DEADZONE = 13'h0800,
    ST_SLEEP = 13'h1000
  } dss_state_t;

endpackage : dss_pkg

// ===== verif/dss_sequencer_sva.sv
`timescale 1ns/1ps
module dss_sequencer_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic power_ok_i,
  input wire logic out_enable_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic acc = psel_i && penable_i && pready_o;
  wire logic bad = (paddr_i >= 8'h38) || (paddr_i[1:0] != 2'h0);
  ready_after_setup_a: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  ready_single_a: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  err_with_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  bad_addr_err_a: assert property (acc && bad |-> pslverr_o && prdata_o == 0)
    else $error("unmapped access not refused");
  good_addr_ok_a: assert property (acc && !bad |-> !pslverr_o)
    else $error("mapped access refused");
  reset_quiet_a: assert property (disable iff (1'b0)
    rst_i |=> !out_enable_o && !pready_o) else $error("output in reset");
  init_hold_a: assert property ($fell(rst_i) |-> !out_enable_o [*3])
    else $error("output during init");
  power_cut_off_a: assert property (!power_ok_i[*6] |-> !out_enable_o)
    else $error("output kept in power cut");
  cover property (pslverr_o);
  cover property ($rose(out_enable_o));
  cover property ($fell(out_enable_o));
endmodule : dss_sequencer_chk
bind dss_sequencer dss_sequencer_chk chk (.clk_i, .rst_i, .psel_i,
  .penable_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .power_ok_i,
  .out_enable_o);

// ===== verif/dss_motor.sv
`timescale 1ns/1ps
module dss_motor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic [15:0] freq_i,
  output logic [15:0] speed_o
);
  // Shaft follows the drive when powered, runs down when coasting
  always_ff @(posedge clk_i) begin
    if (rst_i) speed_o <= 16'h0000;
    else if (en_i) speed_o <= freq_i;
    else if (speed_o != 16'h0000) speed_o <= speed_o - 16'h0001;
  end
endmodule : dss_motor

// ===== verif/drive_start_stop_sequencer_bench.sv
`timescale 1ns/1ps
module drive_start_stop_sequencer_bench;
  logic clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, r;
  logic keypad_run_i, keypad_rev_i, term_fwd_i, term_rev_i, estop_i, e;
  logic power_ok_i, fault_i, fault_reset_i, out_enable_o, out_dir_o;
  logic dc_brake_o, running_o;
  logic [15:0] target_freq_i, speed_i, out_freq_o, dc_current_o;
  int n_mismatch = 0;
  int n_checks = 0;
  dss_sequencer #(.TICK_CYCLES(1)) dut (.clk_i, .rst_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .keypad_run_i, .keypad_rev_i, .term_fwd_i, .term_rev_i,
    .estop_i, .power_ok_i, .fault_i, .fault_reset_i, .target_freq_i,
    .speed_i, .out_enable_o, .out_dir_o, .out_freq_o, .dc_brake_o,
    .dc_current_o, .running_o);
  dss_motor motor (.clk_i, .rst_i, .en_i(out_enable_o),
    .freq_i(out_freq_o), .speed_o(speed_i));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task wait_en(input logic v);
    for (int i = 0; i < 3000 && out_enable_o !== v; i++) @(posedge clk_i);
  endtask : wait_en
  task t_regs;
    for (int i = 0; i < dss_pkg::REG_CNT; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(r, dss_pkg::RST_VAL[i]);
    end
    apb(1'b0, 8'h38, 32'h0);
    chk(r, 32'h0);
    chk(e, 1'b1);
    apb(1'b1, 8'h02, 32'h0);
    chk(e, 1'b1);
  endtask : t_regs
  task t_direct;
    apb(1'b1, 8'h00, 32'h0000_0160);
    keypad_run_i <= 1'b1; // Direct start suits either motor kind
    wait_en(1'b1);
    chk(out_freq_o, 16'h0032);
    chk({out_dir_o, running_o}, 32'h1);
    keypad_rev_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    chk({out_dir_o, running_o}, 32'h3);
    {keypad_run_i, keypad_rev_i} <= 2'b00;
    repeat (6) @(posedge clk_i);
    chk(out_enable_o, 1'b0);
  endtask : t_direct
  task t_source;
    apb(1'b1, 8'h00, 32'h0000_0161);
    keypad_run_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    chk(out_enable_o, 1'b0);
    keypad_run_i <= 1'b0;
    term_fwd_i <= 1'b1;
    wait_en(1'b1);
    chk(out_enable_o, 1'b1);
    term_fwd_i <= 1'b0;
    apb(1'b1, 8'h00, 32'h0000_0162);
    wait_en(1'b0);
    apb(1'b1, 8'h2C, 32'h0000_0001);
    wait_en(1'b1);
    chk(out_enable_o, 1'b1);
    apb(1'b1, 8'h2C, 32'h0000_0000);
    wait_en(1'b0);
    chk(out_enable_o, 1'b0);
  endtask : t_source
  task t_brake;
    int n;
    apb(1'b1, 8'h0C, 32'h0000_0064);
    apb(1'b1, 8'h08, 32'h0000_0001);
    apb(1'b1, 8'h00, 32'h0000_0164);
    keypad_run_i <= 1'b1;
    for (n = 0; n < 100 && dc_brake_o !== 1'b1; n++) @(posedge clk_i);
    chk(dc_current_o, 16'h0064);
    for (n = 0; n < 5000 && dc_brake_o === 1'b1; n++) @(posedge clk_i);
    chk(n >= 1000 && n < 1100, 1'b1);
    wait_en(1'b1);
    chk(out_enable_o, 1'b1);
    keypad_run_i <= 1'b0;
    wait_en(1'b0);
  endtask : t_brake
  task t_power;
    apb(1'b1, 8'h00, 32'h0000_0160);
    keypad_run_i <= 1'b1;
    wait_en(1'b1);
    power_ok_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    power_ok_i <= 1'b1;
    repeat (40) @(posedge clk_i);
    chk(out_enable_o, 1'b0);
    keypad_run_i <= 1'b0;
  endtask : t_power
  task t_estop;
    int n;
    apb(1'b1, 8'h00, 32'h0000_0140);
    keypad_run_i <= 1'b1;
    wait_en(1'b1);
    estop_i <= 1'b1;
    for (n = 0; n < 5000 && out_enable_o === 1'b1; n++) @(posedge clk_i);
    chk(n >= 2000 && n < 2200, 1'b1);
    {keypad_run_i, estop_i} <= 2'b00;
  endtask : t_estop
  task test_done;
    if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    n_mismatch++;
    test_done;
  end
  initial begin
    {rst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = {4'h8, 40'h0};
    {keypad_run_i, keypad_rev_i, term_fwd_i, term_rev_i, estop_i} = 5'h0;
    {power_ok_i, fault_i, fault_reset_i} = 3'b100;
    target_freq_i = 16'h0100;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_direct;
    t_source;
    t_brake;
    t_estop;
    t_power;
    test_done;
  end
endmodule : drive_start_stop_sequencer_bench
